// ==== logic/prbs_gen.sv ====
// Pseudo-random bit generator with 9-bit and 31-bit sequences
`timescale 1ns/10ps
`default_nettype none
module prbs_gen (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // Control
   input  wire logic enable_i,
   input  wire logic hold_i,
   input  wire logic step_i,
   input  wire logic long_i,
   // Sequence out
   output logic      bit_o
);

   logic [30:0] lfsr_q;
   logic [30:0] lfsr_d;
   logic        bit_q;
   logic        bit_d;
   logic        fb;

   // Next state: held seeded while disabled or on hold, otherwise shifts on each step
   always_comb begin
      lfsr_d = lfsr_q;
      bit_d  = bit_q;
      fb     = long_i ? (lfsr_q[30] ^ lfsr_q[27]) : (lfsr_q[8] ^ lfsr_q[4]);
      if (!enable_i) begin
         lfsr_d = '1;
         bit_d  = 1'b0;
      end else if (hold_i) begin
         lfsr_d = '1;
      end else if (step_i) begin
         lfsr_d = {lfsr_q[29:0], fb};
         bit_d  = fb;
      end
   end

   // Register the generator state
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lfsr_q <= '1;
         bit_q  <= 1'b0;
      end else begin
         lfsr_q <= lfsr_d;
         bit_q  <= bit_d;
      end
   end

   assign bit_o = bit_q;

endmodule // prbs_gen
`default_nettype wire

// ==== logic/vco_prbs_consts.svh ====
// Offsets, field positions, reset values and timing counts of the channel control
`ifndef VCO_PRBS_CONSTS_SVH
`define VCO_PRBS_CONSTS_SVH

// Register offsets
`define OFS_CAP_COUNT     8'h08
`define OFS_OVERRIDES     8'h09
`define OFS_GEN_CLK_EN    8'h0D
`define OFS_SD_FORCE      8'h14
`define OFS_DIV_SELECT    8'h18
`define OFS_PUMP_CTRL     8'h1B
`define OFS_OUT_SELECT    8'h1E
`define OFS_LOOP_DAC      8'h1F
`define OFS_GEN_CONFIG    8'h30

// Field positions
`define BIT_OVR_DIV       2
`define BIT_OVR_PUMP      3
`define BIT_OVR_MUX       5
`define BIT_OVR_LOOP      6
`define BIT_OVR_CAP       7
`define BIT_GEN_CLK_EN    5
`define BIT_SD_FORCE_ON   7
`define BIT_SD_FORCE_OFF  6
`define BIT_GEN_ENABLE    4
`define BIT_GEN_CLK_RUN   3
`define DIV_MSB           6
`define DIV_LSB           4
`define MUX_MSB           7
`define MUX_LSB           5
`define DAC_MSB           4
`define SEQ_MSB           1

// Field codes
`define SEQ_CODE_LONG     2'h2
`define PUMP_CODE_OFF     2'h0
`define DIV_CODE_MAX      3'h4

// Reset values
`define RST_ZERO          8'h00
`define RST_OUT_SELECT    8'hE0

// Free-running VCO stand-in: one generator step every so many cycles
`define FREE_RUN_DIV      4'hA

`endif

// ==== logic/vco_prbs_ctrl.sv ====
// Four-channel VCO override and sequence generator control registers
`timescale 1ns/10ps
`default_nettype none
`include "vco_prbs_consts.svh"
module vco_prbs_ctrl (
   // Clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         rst_i,
   // Management port
   input  wire logic         mgmt_wr_i,
   input  wire logic         mgmt_rd_i,
   input  wire logic [1:0]   mgmt_chan_i,
   input  wire logic [7:0]   mgmt_addr_i,
   input  wire logic [7:0]   mgmt_wdata_i,
   output logic [7:0]        mgmt_rdata_o,
   output logic              mgmt_rvalid_o,
   // Channel status
   input  wire logic [3:0]   sig_detect_i,
   input  wire logic [3:0]   cdr_locked_i,
   input  wire logic [3:0]   vco_tick_i,
   input  wire logic [11:0]  auto_div_code_i,
   input  wire logic [3:0]   retimed_bit_i,
   input  wire logic [3:0]   raw_bit_i,
   // Channel controls
   output logic [19:0]       vco_div_ratio_o,
   output logic [3:0]        chan_enable_o,
   output logic [3:0]        pump_enable_o,
   output logic [3:0]        cap_override_o,
   output logic [19:0]       cap_count_o,
   output logic [3:0]        loop_filter_voltage_source_en_o,
   output logic [19:0]       loop_filter_voltage_source_o,
   output logic [11:0]       out_src_o,
   output logic [3:0]        out_bit_o
);

   localparam int NCH = 4;

   // Per-channel register copies
   // Output select resets with its mux field at mute
   logic [7:0] cap_q [NCH];
   logic [7:0] cap_d [NCH];
   logic [7:0] ovr_q [NCH];
   logic [7:0] ovr_d [NCH];
   logic [7:0] gck_q [NCH];
   logic [7:0] gck_d [NCH];
   logic [7:0] sdf_q [NCH];
   logic [7:0] sdf_d [NCH];
   logic [7:0] div_q [NCH];
   logic [7:0] div_d [NCH];
   logic [7:0] pmp_q [NCH];
   logic [7:0] pmp_d [NCH];
   logic [7:0] osl_q [NCH];
   logic [7:0] osl_d [NCH];
   logic [7:0] dac_q [NCH];
   logic [7:0] dac_d [NCH];
   logic [7:0] gcf_q [NCH];
   logic [7:0] gcf_d [NCH];

   // Read answer
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       rvalid_q;
   logic       rvalid_d;

   // Detect synchroniser, free-run pacing and generator bits
   logic [3:0] sd_meta_q;
   logic [3:0] sd_sync_q;
   logic [3:0] tick_cnt_q;
   logic [3:0] tick_cnt_d;
   logic       free_tick;
   logic [3:0] prbs_bit;

   // Divide code to ratio, codes above the last valid one give divide 1
   // Software must not write those codes; the fallback only keeps it safe
   function automatic logic [4:0] div_ratio(input logic [2:0] code);
      logic [4:0] r;
      r = 5'h01;
      if (code <= `DIV_CODE_MAX) begin
         r = 5'(5'h01 << code);
      end
      return r;
   endfunction

   // Register writes, each reaching only the addressed channel
   // A write to an unmapped offset changes nothing
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         cap_d[c] = cap_q[c];
         ovr_d[c] = ovr_q[c];
         gck_d[c] = gck_q[c];
         sdf_d[c] = sdf_q[c];
         div_d[c] = div_q[c];
         pmp_d[c] = pmp_q[c];
         osl_d[c] = osl_q[c];
         dac_d[c] = dac_q[c];
         gcf_d[c] = gcf_q[c];
         if (mgmt_wr_i && (mgmt_chan_i == 2'(c))) begin
            case (mgmt_addr_i)
               `OFS_CAP_COUNT:  cap_d[c] = mgmt_wdata_i;
               `OFS_OVERRIDES:  ovr_d[c] = mgmt_wdata_i;
               `OFS_GEN_CLK_EN: gck_d[c] = mgmt_wdata_i;
               `OFS_SD_FORCE:   sdf_d[c] = mgmt_wdata_i;
               `OFS_DIV_SELECT: div_d[c] = mgmt_wdata_i;
               `OFS_PUMP_CTRL:  pmp_d[c] = mgmt_wdata_i;
               `OFS_OUT_SELECT: osl_d[c] = mgmt_wdata_i;
               `OFS_LOOP_DAC:   dac_d[c] = mgmt_wdata_i;
               `OFS_GEN_CONFIG: gcf_d[c] = mgmt_wdata_i;
               default: ;
            endcase
         end
      end
   end

   // Register the control copies
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int c = 0; c < NCH; c++) begin
            cap_q[c] <= `RST_ZERO;
            ovr_q[c] <= `RST_ZERO;
            gck_q[c] <= `RST_ZERO;
            sdf_q[c] <= `RST_ZERO;
            div_q[c] <= `RST_ZERO;
            pmp_q[c] <= `RST_ZERO;
            osl_q[c] <= `RST_OUT_SELECT;
            dac_q[c] <= `RST_ZERO;
            gcf_q[c] <= `RST_ZERO;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            cap_q[c] <= cap_d[c];
            ovr_q[c] <= ovr_d[c];
            gck_q[c] <= gck_d[c];
            sdf_q[c] <= sdf_d[c];
            div_q[c] <= div_d[c];
            pmp_q[c] <= pmp_d[c];
            osl_q[c] <= osl_d[c];
            dac_q[c] <= dac_d[c];
            gcf_q[c] <= gcf_d[c];
         end
      end
   end

   // Read data for the addressed channel, unmapped offsets read zero
   // The answer pulse follows every read, mapped or not
   always_comb begin
      rdata_d  = rdata_q;
      rvalid_d = mgmt_rd_i;
      if (mgmt_rd_i) begin
         case (mgmt_addr_i)
            `OFS_CAP_COUNT:  rdata_d = cap_q[mgmt_chan_i];
            `OFS_OVERRIDES:  rdata_d = ovr_q[mgmt_chan_i];
            `OFS_GEN_CLK_EN: rdata_d = gck_q[mgmt_chan_i];
            `OFS_SD_FORCE:   rdata_d = sdf_q[mgmt_chan_i];
            `OFS_DIV_SELECT: rdata_d = div_q[mgmt_chan_i];
            `OFS_PUMP_CTRL:  rdata_d = pmp_q[mgmt_chan_i];
            `OFS_OUT_SELECT: rdata_d = osl_q[mgmt_chan_i];
            `OFS_LOOP_DAC:   rdata_d = dac_q[mgmt_chan_i];
            `OFS_GEN_CONFIG: rdata_d = gcf_q[mgmt_chan_i];
            default:         rdata_d = `RST_ZERO;
         endcase
      end
   end

   // Register the read answer
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q  <= `RST_ZERO;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Read outputs come straight from flip-flops
   assign mgmt_rdata_o  = rdata_q;
   assign mgmt_rvalid_o = rvalid_q;

   // Signal detect pins pass two flip-flops
   // Detect comes from the analog side, so only the second stage is read
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sd_meta_q <= 4'h0;
         sd_sync_q <= 4'h0;
      end else begin
         sd_meta_q <= sig_detect_i;
         sd_sync_q <= sd_meta_q;
      end
   end

   // Free-running VCO stand-in, one-cycle step enable
   // The real oscillator is analog; this counter only paces the generator
   always_comb begin
      tick_cnt_d = tick_cnt_q + 4'h1;
      if (tick_cnt_q == (`FREE_RUN_DIV - 4'h1)) begin
         tick_cnt_d = 4'h0;
      end
   end

   // Register the pacing counter
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_cnt_q <= 4'h0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
      end
   end

   // Step pulse on the counter's zero state
   assign free_tick = (tick_cnt_q == 4'h0);

   // Per-channel control outputs and generator
   // Each channel reads only its own copies, so channels stay apart
   for (genvar c = 0; c < NCH; c++) begin : g_chan
      logic       sd_on;
      logic       pump_off;
      logic       gen_step;
      logic [2:0] sel;
      logic [2:0] div_code;
      // Registered output bit
      logic       out_d;
      logic       out_q;

      // Forced detect enables the channel; the force-off bit powers it down over any input
      assign sd_on = (sdf_q[c][`BIT_SD_FORCE_ON] &
                      ~sdf_q[c][`BIT_SD_FORCE_OFF]) |
                     (sd_sync_q[c] & ~sdf_q[c][`BIT_SD_FORCE_OFF]);
      assign chan_enable_o[c] = sd_on;

      // Charge pump off makes the VCO free-run
      // Both the override bit and the pump field must agree
      assign pump_off = ovr_q[c][`BIT_OVR_PUMP] &
                        (pmp_q[c][1:0] == `PUMP_CODE_OFF);
      assign pump_enable_o[c] = ~pump_off;

      // Divide ratio: automatic unless overridden
      assign div_code = ovr_q[c][`BIT_OVR_DIV] ?
                        div_q[c][`DIV_MSB:`DIV_LSB] :
                        auto_div_code_i[3*c +: 3];
      assign vco_div_ratio_o[5*c +: 5] = div_ratio(div_code);

      // Capacitor and loop filter overrides
      assign cap_override_o[c] = ovr_q[c][`BIT_OVR_CAP];
      assign cap_count_o[5*c +: 5] = cap_q[c][`DAC_MSB:0];
      assign loop_filter_voltage_source_en_o[c] =
             ovr_q[c][`BIT_OVR_LOOP];
      assign loop_filter_voltage_source_o[5*c +: 5] =
             dac_q[c][`DAC_MSB:0];

      // Step on the locked VCO, or on the free-running one
      // Unless the pump is off, there is nothing to step on without a locked, detected input
      assign gen_step = gck_q[c][`BIT_GEN_CLK_EN] &
                        (pump_off ? free_tick :
                         (vco_tick_i[c] & cdr_locked_i[c] & sd_on));

      // One generator per channel, paced by its own step
      prbs_gen u_prbs (
         .sys_clk_i (sys_clk_i),
         .rst_i     (rst_i),
         .enable_i  (osl_q[c][`BIT_GEN_ENABLE]),
         .hold_i    (~gcf_q[c][`BIT_GEN_CLK_RUN]),
         .step_i    (gen_step),
         .long_i    (gcf_q[c][`SEQ_MSB:0] == `SEQ_CODE_LONG),
         .bit_o     (prbs_bit[c])
      );

      // Output source: override, then mute when undetected, locked default, unlocked field
      // Detected but unlocked, without override, shows the select field, mute by default
      always_comb begin
         if (ovr_q[c][`BIT_OVR_MUX]) begin
            sel = osl_q[c][`MUX_MSB:`MUX_LSB];
         end else if (!sd_on) begin
            sel = vco_prbs_pkg::OUT_MUTE;
         end else if (cdr_locked_i[c]) begin
            sel = vco_prbs_pkg::OUT_RETIMED;
         end else begin
            sel = osl_q[c][`MUX_MSB:`MUX_LSB];
         end
      end
      assign out_src_o[3*c +: 3] = sel;

      // Output bit per source; clock sources are shown muted here
      // Only raw data, retimed data and the generator have a bit to show
      always_comb begin
         case (sel)
            vco_prbs_pkg::OUT_RAW:     out_d = raw_bit_i[c];
            vco_prbs_pkg::OUT_RETIMED: out_d = retimed_bit_i[c];
            vco_prbs_pkg::OUT_PRBS:    out_d = prbs_bit[c];
            default:                   out_d = 1'b0;
         endcase
      end

      // Register the output bit
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
         if (rst_i) begin
            out_q <= 1'b0;
         end else begin
            out_q <= out_d;
         end
      end

      assign out_bit_o[c] = out_q;
   end

endmodule // vco_prbs_ctrl
`default_nettype wire

// ==== logic/vco_prbs_pkg.sv ====
// Types shared by the channel control files
`default_nettype none
package vco_prbs_pkg;

   // Output multiplexer sources
   typedef enum logic [2:0] {
      OUT_RAW     = 3'h0,
      OUT_RETIMED = 3'h1,
      OUT_ICLK    = 3'h2,
      OUT_QCLK    = 3'h3,
      OUT_PRBS    = 3'h4,
      OUT_CLK10M  = 3'h5,
      OUT_BAD     = 3'h6,
      OUT_MUTE    = 3'h7
   } out_src_e;

   typedef logic [1:0] chan_t;
   typedef logic [7:0] byte_t;

endpackage : vco_prbs_pkg
`default_nettype wire

// ==== test/test_vco_override_and_prbs_control.sv ====
// Self-checking bench for the channel control registers
`timescale 1ns/10ps
`default_nettype none
`include "vco_prbs_consts.svh"
module test_vco_override_and_prbs_control;
   logic        sys_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        mgmt_wr_i = 1'b0;
   logic        mgmt_rd_i = 1'b0;
   logic [1:0]  mgmt_chan_i = 2'h0;
   logic [7:0]  mgmt_addr_i = 8'h00;
   logic [7:0]  mgmt_wdata_i = 8'h00;
   logic [3:0]  sig_detect_i = 4'h2;
   logic [3:0]  cdr_locked_i = 4'h2;
   logic [3:0]  vco_tick_i = 4'h0;
   logic [11:0] auto_div_code_i = 12'h000;
   logic [3:0]  retimed_bit_i = 4'h0;
   logic [3:0]  raw_bit_i = 4'h0;
   logic [7:0]  mgmt_rdata_o;
   logic        mgmt_rvalid_o;
   logic [19:0] vco_div_ratio_o, cap_count_o, loop_filter_voltage_source_o;
   logic [3:0]  chan_enable_o, pump_enable_o, cap_override_o, out_bit_o;
   logic [3:0]  loop_filter_voltage_source_en_o;
   logic [11:0] out_src_o;
   logic [31:0] seed = 32'h10E7F8AD;
   logic [7:0]  mem [36];
   logic [7:0]  ofs [9] = '{`OFS_CAP_COUNT, `OFS_OVERRIDES, `OFS_GEN_CLK_EN,
      `OFS_SD_FORCE, `OFS_DIV_SELECT, `OFS_PUMP_CTRL, `OFS_OUT_SELECT,
      `OFS_LOOP_DAC, `OFS_GEN_CONFIG};
   int          n_mismatch = 0;
   int          comparisons = 0;

   vco_prbs_ctrl uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .mgmt_wr_i(mgmt_wr_i), .mgmt_rd_i(mgmt_rd_i), .mgmt_chan_i(mgmt_chan_i),
      .mgmt_addr_i(mgmt_addr_i), .mgmt_wdata_i(mgmt_wdata_i),
      .mgmt_rdata_o(mgmt_rdata_o), .mgmt_rvalid_o(mgmt_rvalid_o),
      .sig_detect_i(sig_detect_i), .cdr_locked_i(cdr_locked_i),
      .vco_tick_i(vco_tick_i), .auto_div_code_i(auto_div_code_i),
      .retimed_bit_i(retimed_bit_i), .raw_bit_i(raw_bit_i),
      .vco_div_ratio_o(vco_div_ratio_o), .chan_enable_o(chan_enable_o),
      .pump_enable_o(pump_enable_o), .cap_override_o(cap_override_o),
      .cap_count_o(cap_count_o),
      .loop_filter_voltage_source_en_o(loop_filter_voltage_source_en_o),
      .loop_filter_voltage_source_o(loop_filter_voltage_source_o),
      .out_src_o(out_src_o), .out_bit_o(out_bit_o));

   // Next state of the stimulus shift register
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Divide ratio that a divider code stands for
   function automatic logic [7:0] div_expect(input logic [2:0] code);
      case (code)
         3'h0:    return 8'h01;
         3'h1:    return 8'h02;
         3'h2:    return 8'h04;
         3'h3:    return 8'h08;
         3'h4:    return 8'h10;
         default: return 8'h01;
      endcase
   endfunction

   // Clock
   always #5 sys_clk_i = ~sys_clk_i;

   // Random line activity from the shift register, just after each edge
   always @(posedge sys_clk_i) begin
      #1;
      seed = lfsr_next(seed);
      vco_tick_i = seed[3:0];
      raw_bit_i = seed[7:4];
      retimed_bit_i = seed[11:8];
   end

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [1:0] c, input logic [7:0] a, d);
      @(posedge sys_clk_i);
      #1;
      {mgmt_wr_i, mgmt_chan_i, mgmt_addr_i, mgmt_wdata_i} = {1'b1, c, a, d};
      @(posedge sys_clk_i);
      #1;
      mgmt_wr_i = 1'b0;
   endtask

   task automatic rd(input logic [1:0] c, input logic [7:0] a, e);
      @(posedge sys_clk_i);
      #1;
      {mgmt_rd_i, mgmt_chan_i, mgmt_addr_i} = {1'b1, c, a};
      @(posedge sys_clk_i);
      #1;
      mgmt_rd_i = 1'b0;
      chk({7'h0, mgmt_rvalid_o}, 8'h01);
      chk(mgmt_rdata_o, e);
   endtask

   // Output bits of channel 2 must follow the chosen recurrence
   task automatic seq_check(input int n, input int t);
      logic b [80];
      int bad = 0;
      int ones = 0;
      repeat (400) @(posedge sys_clk_i);
      for (int i = 0; i < 80; i++) begin
         repeat (`FREE_RUN_DIV) @(posedge sys_clk_i);
         #1;
         b[i] = out_bit_o[2];
         ones += int'(b[i]);
      end
      for (int i = n; i < 80; i++) bad += int'(b[i] !== (b[i-n] ^ b[i-t]));
      chk(8'(bad), 8'h00);
      chk({7'h0, ones > 0}, 8'h01);
   endtask

   // Output bit of channel 2 must not move
   task automatic steady();
      logic g;
      logic moved = 1'b0;
      repeat (3) @(posedge sys_clk_i);
      #1;
      g = out_bit_o[2];
      repeat (60) begin
         @(posedge sys_clk_i);
         #1;
         moved |= (out_bit_o[2] !== g);
      end
      chk({7'h0, moved}, 8'h00);
   endtask

   task automatic tally_and_finish();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #200000;
      n_mismatch++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge sys_clk_i);
      #1;
      rst_i = 1'b0;
      for (int c = 0; c < 4; c++) begin
         rd(2'(c), `OFS_OVERRIDES, `RST_ZERO);
         rd(2'(c), `OFS_OUT_SELECT, `RST_OUT_SELECT);
      end
      rd(2'h0, 8'h55, 8'h00);
      // Random contents everywhere, then read back
      for (int i = 0; i < 36; i++) begin
         mem[i] = seed[7:0];
         if (ofs[i % 9] == `OFS_DIV_SELECT) mem[i][6] = 1'b0;
         wr(2'(i / 9), ofs[i % 9], mem[i]);
      end
      for (int i = 35; i >= 0; i--) rd(2'(i / 9), ofs[i % 9], mem[i]);
      // Divider codes, then automatic choice
      auto_div_code_i = {3'h3, 3'h1, 3'h4, 3'h2};
      for (int c = 0; c < 4; c++) begin
         wr(2'(c), `OFS_PUMP_CTRL, 8'h00);
         wr(2'(c), `OFS_OVERRIDES, 8'h0C);
         for (int k = 0; k < 5; k++) begin
            wr(2'(c), `OFS_DIV_SELECT, {1'b0, 3'(k), 4'h0});
            chk({3'h0, vco_div_ratio_o[c*5+:5]}, div_expect(3'(k)));
         end
         wr(2'(c), `OFS_OVERRIDES, 8'h00);
         chk({3'h0, vco_div_ratio_o[c*5+:5]},
            div_expect(auto_div_code_i[c*3+:3]));
      end
      // Locked channel 1 shows retimed data; channel 3 follows select
      wr(2'h1, `OFS_SD_FORCE, 8'h00);
      chk({5'h0, out_src_o[5:3]}, 8'h01);
      wr(2'h3, `OFS_OVERRIDES, 8'h20);
      for (int k = 0; k < 8; k++) begin
         wr(2'h3, `OFS_OUT_SELECT, {3'(k), 5'h00});
         chk({5'h0, out_src_o[11:9]}, 8'(k));
      end
      // Free-running sequence on channel 2
      wr(2'h2, `OFS_SD_FORCE, 8'h00);
      repeat (4) @(posedge sys_clk_i);
      chk({7'h0, chan_enable_o[2]}, 8'h00);
      wr(2'h2, `OFS_SD_FORCE, 8'h80);
      repeat (4) @(posedge sys_clk_i);
      chk({7'h0, chan_enable_o[2]}, 8'h01);
      wr(2'h2, `OFS_OVERRIDES, 8'h08);
      wr(2'h2, `OFS_PUMP_CTRL, 8'h00);
      chk({7'h0, pump_enable_o[2]}, 8'h00);
      wr(2'h2, `OFS_OVERRIDES, 8'h8C);
      wr(2'h2, `OFS_CAP_COUNT, 8'h08);
      chk({2'h0, cap_override_o[2], cap_count_o[14:10]}, 8'h28);
      wr(2'h2, `OFS_OVERRIDES, 8'hCC);
      wr(2'h2, `OFS_LOOP_DAC, 8'h12);
      chk({2'h0, loop_filter_voltage_source_en_o[2],
         loop_filter_voltage_source_o[14:10]}, 8'h32);
      wr(2'h2, `OFS_OUT_SELECT, 8'hF0);
      wr(2'h2, `OFS_GEN_CONFIG, 8'h00);
      wr(2'h2, `OFS_GEN_CONFIG, 8'h08);
      wr(2'h2, `OFS_GEN_CLK_EN, 8'h20);
      wr(2'h2, `OFS_OVERRIDES, 8'hEC);
      wr(2'h2, `OFS_OUT_SELECT, 8'h90);
      chk({5'h0, out_src_o[8:6]}, 8'h04);
      seq_check(9, 5);
      wr(2'h2, `OFS_GEN_CONFIG, 8'h02);
      steady();
      wr(2'h2, `OFS_GEN_CONFIG, 8'h0A);
      seq_check(31, 28);
      wr(2'h2, `OFS_OUT_SELECT, 8'h80);
      steady();
      wr(2'h2, `OFS_OVERRIDES, 8'h00);
      chk({6'h0, pump_enable_o[2], cap_override_o[2]}, 8'h02);
      tally_and_finish();
   end
endmodule // test_vco_override_and_prbs_control
`default_nettype wire

// ==== test/vco_prbs_ctrl_props.sv ====
// Checker for the channel control register block
`timescale 1ns/10ps
`default_nettype none
module vco_prbs_ctrl_props (
   // Clock, reset and management port
   input wire logic        sys_clk_i,
   input wire logic        rst_i,
   input wire logic        mgmt_wr_i,
   input wire logic        mgmt_rd_i,
   input wire logic [1:0]  mgmt_chan_i,
   input wire logic [7:0]  mgmt_addr_i,
   input wire logic [7:0]  mgmt_wdata_i,
   input wire logic [7:0]  mgmt_rdata_o,
   input wire logic        mgmt_rvalid_o,
   // Channel status and controls
   input wire logic [11:0] auto_div_code_i,
   input wire logic [19:0] vco_div_ratio_o,
   input wire logic [3:0]  pump_enable_o,
   input wire logic [3:0]  cap_override_o,
   input wire logic [19:0] cap_count_o,
   input wire logic [3:0]  loop_filter_voltage_source_en_o,
   input wire logic [19:0] loop_filter_voltage_source_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Write to channel 0 at one offset
   sequence wr0(a);
      mgmt_wr_i && mgmt_chan_i == 2'h0 && mgmt_addr_i == a;
   endsequence
   rd_answer_a: assert property (mgmt_rd_i |=> mgmt_rvalid_o)
      else $error("read not answered");
   rd_quiet_a: assert property (!mgmt_rd_i |=> !mgmt_rvalid_o)
      else $error("answer without read");
   unmapped_rd_a: assert property
      (mgmt_rd_i && mgmt_addr_i == 8'h55 |=> mgmt_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   cap_count_a: assert property (wr0(8'h08) |=>
      cap_count_o[4:0] == $past(mgmt_wdata_i[4:0]))
      else $error("capacitor count not taken");
   loop_value_a: assert property (wr0(8'h1F) |=>
      loop_filter_voltage_source_o[4:0] == $past(mgmt_wdata_i[4:0]))
      else $error("loop filter value not taken");
   ovr_bits_a: assert property (wr0(8'h09) |=>
      cap_override_o[0] == $past(mgmt_wdata_i[7]) &&
      loop_filter_voltage_source_en_o[0] == $past(mgmt_wdata_i[6]))
      else $error("override bits not taken");
   ovr_clear_a: assert property (wr0(8'h09) ##0 mgmt_wdata_i == 8'h00 |=>
      pump_enable_o[0] &&
      vco_div_ratio_o[4:0] == (5'h01 << auto_div_code_i[2:0]))
      else $error("overrides not cancelled");
   chan_apart_a: assert property (mgmt_wr_i && mgmt_chan_i != 2'h0 |=>
      $stable(cap_count_o[4:0]) && $stable(cap_override_o[0]))
      else $error("other channel disturbed");
endmodule // vco_prbs_ctrl_props
bind vco_prbs_ctrl vco_prbs_ctrl_props u_props (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .mgmt_wr_i(mgmt_wr_i),
   .mgmt_rd_i(mgmt_rd_i), .mgmt_chan_i(mgmt_chan_i),
   .mgmt_addr_i(mgmt_addr_i), .mgmt_wdata_i(mgmt_wdata_i),
   .mgmt_rdata_o(mgmt_rdata_o), .mgmt_rvalid_o(mgmt_rvalid_o),
   .auto_div_code_i(auto_div_code_i), .vco_div_ratio_o(vco_div_ratio_o),
   .pump_enable_o(pump_enable_o), .cap_override_o(cap_override_o),
   .cap_count_o(cap_count_o),
   .loop_filter_voltage_source_en_o(loop_filter_voltage_source_en_o),
   .loop_filter_voltage_source_o(loop_filter_voltage_source_o));
`default_nettype wire
